/* File: fpd_defines.vh */
`ifndef FPD_DEFINES_VH
`define FPD_DEFINES_VH

// command codes of the byte register port
`define FPD_CMD_FAULT_CFG    8'h2D
`define FPD_CMD_SUPPLY_V     8'h2E

// field positions in four_pair_fault_config
`define FPD_THR_SEL_LO       0
`define FPD_PCT_EN_LO        2
`define FPD_CFG_RESET        8'h00
`define FPD_SUPPLY_RESET     14'h0000

// operating mode codes of a channel pair
`define FPD_MODE_OFF         2'h0
`define FPD_MODE_MANUAL      2'h1
`define FPD_MODE_SEMI        2'h2
`define FPD_MODE_AUTO        2'h3

// current levels in ADC codes (step about 70.19 uA)
`define FPD_I_4P5MA          14'h0040
`define FPD_I_6P5MA          14'h005C
`define FPD_I_75MA           14'h042C
`define FPD_I_30MA           14'h01AB
`define FPD_I_MIN_HOLD       14'h005C

// hold timing in microseconds and derived cycle counts
`define FPD_CLK_MHZ          16'h0019
`define FPD_DROPOUT_US       16'h012C
`define FPD_PULSE_US         16'h003C
`define FPD_DROPOUT_CYC      (`FPD_DROPOUT_US * `FPD_CLK_MHZ)
`define FPD_PULSE_CYC        (`FPD_PULSE_US * `FPD_CLK_MHZ)
`define FPD_TMR_W            16

`endif

/* File: fpd_hold_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defines.vh"

module fpd_hold_timer (
    input  wire                   sys_clk,
    input  wire                   sys_rst,
    input  wire                   run,
    input  wire [`FPD_TMR_W-1:0]  limit,
    output reg                    expired_r
);

    reg [`FPD_TMR_W-1:0] cnt_r;    // cycles spent below level

    // count while the channel stays below its level; any rise restarts
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r     <= {`FPD_TMR_W{1'b0}};
            expired_r <= 1'b0;
        end else if (!run) begin
            cnt_r     <= {`FPD_TMR_W{1'b0}};
            expired_r <= 1'b0;
        end else if (cnt_r >= limit) begin
            // saturate so a long dip cannot wrap back to zero
            expired_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(`FPD_TMR_W-1){1'b0}}, 1'b1};
        end
    end

endmodule
`default_nettype wire

/* File: fpd_reg_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defines.vh"

module fpd_reg_port (
    input  wire         sys_clk,
    input  wire         sys_rst,
    input  wire         cmd_stb,
    input  wire [7:0]   cmd_byte,
    input  wire         wr_stb,
    input  wire [7:0]   wr_byte,
    input  wire         rd_stb,
    input  wire [1:0]   hw_set_pct,
    input  wire [1:0]   hw_set_thr,
    input  wire [1:0]   hw_thr_val,
    input  wire         supply_stb,
    input  wire [13:0]  supply_code,
    output reg  [7:0]   cfg_r,
    output reg  [7:0]   rd_byte_r,
    output reg          rd_valid_r
);

    reg [7:0]  cmd_r;              // current command code
    reg        ptr_r;              // byte pointer of a two-byte read
    reg [13:0] volt_r;             // supply_voltage_reading contents
    reg [5:0]  hi_snap_r;          // high byte frozen at low-byte read
    reg [7:0]  cfg_nxt;
    integer    i;

    // software write first, hardware sets after so that a set wins
    always @* begin
        cfg_nxt = cfg_r;
        if (wr_stb && cmd_r == `FPD_CMD_FAULT_CFG) begin
            cfg_nxt = wr_byte;
        end
        for (i = 0; i < 2; i = i + 1) begin
            if (hw_set_pct[i]) begin
                cfg_nxt[`FPD_PCT_EN_LO+i] = 1'b1;
            end
            if (hw_set_thr[i]) begin
                cfg_nxt[`FPD_THR_SEL_LO+i] = hw_thr_val[i];
            end
        end
    end

    // command latch, config store and voltage store
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r  <= 8'h00;
            cfg_r  <= `FPD_CFG_RESET;
            volt_r <= `FPD_SUPPLY_RESET;
        end else begin
            if (cmd_stb) begin
                cmd_r <= cmd_byte;
            end
            cfg_r <= cfg_nxt;
            if (supply_stb) begin
                volt_r <= supply_code;
            end
        end
    end

    // read path; unmapped commands read as zero, writes to read-only are ignored
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_r      <= 1'b0;
            hi_snap_r  <= 6'h00;
            rd_byte_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_stb;
            if (cmd_stb) begin
                ptr_r <= 1'b0;
            end else if (rd_stb) begin
                ptr_r <= ~ptr_r;
                if (cmd_r == `FPD_CMD_FAULT_CFG) begin
                    rd_byte_r <= cfg_r;
                end else if (cmd_r == `FPD_CMD_SUPPLY_V) begin
                    if (!ptr_r) begin
                        rd_byte_r <= volt_r[7:0];
                        hi_snap_r <= volt_r[13:8];
                    end else begin
                        rd_byte_r <= {2'b00, hi_snap_r};
                    end
                end else begin
                    rd_byte_r <= 8'h00;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: fpd_fault_mgmt.v */
// What this block does
// - cleared enable bit skips summed power check
// - current-limit faults always drop channels
// - auto modes set enable for single-signature
// - select bit picks 4.5mA or 6.5mA, manual always 6.5mA
// - dual signature: select set, per-channel disconnect
// - single signature select follows assigned class
// - class 0-4 low select: immediate partial disconnect
// - disabled channel returns above 75 mA
// - summed check off in partial or below 30mA
// - class 5-8 high select: both must drop
// - select cleared later: 6.5mA per channel
// - manual modes: independent, fault flag set
// - supply voltage held as 14-bit code
// - voltage read low byte then high
// - supply measured against analog ground
// - set enable bit applies summed power check
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defines.vh"

module fpd_fault_mgmt #(
    parameter [`FPD_TMR_W-1:0] DROP_CYC  = `FPD_DROPOUT_CYC,
    parameter [`FPD_TMR_W-1:0] PULSE_CYC = `FPD_PULSE_CYC
) (
    input  wire         sys_clk,
    input  wire         sys_rst,
    // byte register port fed by the serial bus engine
    input  wire         cmd_stb,
    input  wire [7:0]   cmd_byte,
    input  wire         wr_stb,
    input  wire [7:0]   wr_byte,
    input  wire         rd_stb,
    output wire [7:0]   rd_byte,
    output wire         rd_valid,
    // supply converter result, referred to analog ground
    input  wire         supply_stb,
    input  wire [13:0]  supply_code,
    // per pair: load and power-up information
    input  wire [1:0]   pair_turn_on,
    input  wire [1:0]   pair_four_pair,
    input  wire [1:0]   pair_dual_sig,
    input  wire [7:0]   pair_class,
    input  wire [3:0]   pair_mode,
    // per channel: current code and limit fault
    input  wire [55:0]  ch_current,
    input  wire [3:0]   current_limit_fault,
    output wire [3:0]   ch_enable,
    output wire [3:0]   disconnect_fault_flag,
    output wire [1:0]   summed_cut_active,
    output wire [1:0]   partial_disconnect,
    output wire [7:0]   four_pair_fault_config
);

    // true when a current code sits below a level
    function below;
        input [13:0] cur;
        input [13:0] lvl;
        begin
            below = (cur < lvl);
        end
    endfunction

    wire [7:0]  cfg;                // live four_pair_fault_config
    wire [3:0]  tmr_exp;            // hold timer expired per channel
    wire [3:0]  tmr_run;            // hold timer running per channel
    wire [1:0]  set_pct;            // hardware set of summed enable
    wire [1:0]  set_thr;            // hardware write of select bit
    wire [1:0]  thr_val;            // value written with set_thr
    wire [1:0]  manual_w;           // pair latched in manual mode

    assign four_pair_fault_config = cfg;

    // voltage register lives in the port
    // code arrives from the ground-referred converter
    fpd_reg_port u_regs (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .cmd_stb     (cmd_stb),
        .cmd_byte    (cmd_byte),
        .wr_stb      (wr_stb),
        .wr_byte     (wr_byte),
        .rd_stb      (rd_stb),
        .hw_set_pct  (set_pct),
        .hw_set_thr  (set_thr),
        .hw_thr_val  (thr_val),
        .supply_stb  (supply_stb),
        .supply_code (supply_code),
        .cfg_r       (cfg),
        .rd_byte_r   (rd_byte),
        .rd_valid_r  (rd_valid)
    );

    genvar c;
    genvar p;

    // one dropout timer per channel
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_ch
            wire        man  = manual_w[c/2];
            wire        thr  = cfg[`FPD_THR_SEL_LO + c/2];
            wire [13:0] cur  = ch_current[c*14 +: 14];
            wire [13:0] lvl;
            wire [`FPD_TMR_W-1:0] lim;
            // cleared bit falls back to 6.5mA
            assign lvl = man ? `FPD_I_MIN_HOLD :
                         (thr ? `FPD_I_4P5MA : `FPD_I_6P5MA);
            assign lim = man ? DROP_CYC : DROP_CYC + PULSE_CYC;
            assign tmr_run[c] = ch_enable[c] & below(cur, lvl);
            fpd_hold_timer u_tmr (
                .sys_clk   (sys_clk),
                .sys_rst   (sys_rst),
                .run       (tmr_run[c]),
                .limit     (lim),
                .expired_r (tmr_exp[c])
            );
        end
    endgenerate

    // disconnect control for each channel pair
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pair
            reg  [1:0]  en_r;           // channel enables a, b
            reg  [1:0]  disf_r;         // disconnect fault pulses
            reg         partial_r;      // one channel parked low
            reg         dual_r;         // load latched as dual sig
            reg         four_r;         // port latched as 4-pair
            reg         man_r;          // powered in manual/diag
            reg  [3:0]  cls_r;          // assigned class at turn-on
            reg         pct_set_r;      // set summed enable pulse
            reg         thr_set_r;      // write select bit pulse
            reg         thr_val_r;      // value for select bit
            reg         cut_r;          // summed check active
            reg  [1:0]  en_nxt;
            reg  [1:0]  disf_nxt;
            reg         partial_nxt;
            wire [13:0] cur_a = ch_current[(2*p)*14 +: 14];
            wire [13:0] cur_b = ch_current[(2*p+1)*14 +: 14];
            wire        thr   = cfg[`FPD_THR_SEL_LO + p];
            wire        pct   = cfg[`FPD_PCT_EN_LO + p];
            wire [1:0]  exp_w = tmr_exp[2*p+1 : 2*p];
            wire [1:0]  low_w;
            wire [1:0]  mode  = pair_mode[2*p +: 2];
            wire [3:0]  cls   = pair_class[4*p +: 4];
            wire        hi_cls = (cls_r >= 4'h5);
            wire        auto_m = (mode == `FPD_MODE_AUTO) ||
                                 (mode == `FPD_MODE_SEMI);

            // immediate below-level view for partial disconnect
            assign low_w[0] = below(cur_a, `FPD_I_6P5MA);
            assign low_w[1] = below(cur_b, `FPD_I_6P5MA);

            // next channel state from faults and disconnect policy
            always @* begin
                en_nxt      = en_r;
                disf_nxt    = 2'b00;
                partial_nxt = partial_r;
                if (!four_r || man_r || dual_r || (!thr && hi_cls)) begin
                    disf_nxt    = exp_w & en_r;
                    en_nxt      = en_r & ~exp_w;
                end else if (thr) begin
                    if (&exp_w) begin
                        disf_nxt = en_r;
                        en_nxt   = 2'b00;
                    end
                end else if (!partial_r) begin
                    // park the low channel at once
                    if (en_r == 2'b11 && low_w[1]) begin
                        en_nxt      = 2'b01;
                        partial_nxt = 1'b1;
                    end else if (en_r == 2'b11 && low_w[0]) begin
                        en_nxt      = 2'b10;
                        partial_nxt = 1'b1;
                    end else begin
                        disf_nxt = exp_w & en_r;
                        en_nxt   = en_r & ~exp_w;
                    end
                end else if (|(exp_w & en_r)) begin
                    // remaining channel lost its hold current
                    disf_nxt    = en_r;
                    en_nxt      = 2'b00;
                    partial_nxt = 1'b0;
                end else if ((en_r[0] && !below(cur_a, `FPD_I_75MA)) ||
                             (en_r[1] && !below(cur_b, `FPD_I_75MA))) begin
                    en_nxt      = 2'b11;
                    partial_nxt = 1'b0;
                end
                // limit faults act regardless of config
                en_nxt = en_nxt & ~current_limit_fault[2*p+1 : 2*p];
                if (en_nxt == 2'b00) begin
                    partial_nxt = 1'b0;
                end
            end

            // turn-on latches the load type and requests bit updates
            always @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    en_r      <= 2'b00;
                    disf_r    <= 2'b00;
                    partial_r <= 1'b0;
                    dual_r    <= 1'b0;
                    four_r    <= 1'b0;
                    man_r     <= 1'b0;
                    cls_r     <= 4'h0;
                    pct_set_r <= 1'b0;
                    thr_set_r <= 1'b0;
                    thr_val_r <= 1'b0;
                end else if (pair_turn_on[p]) begin
                    en_r      <= ~current_limit_fault[2*p+1 : 2*p];
                    disf_r    <= 2'b00;
                    partial_r <= 1'b0;
                    dual_r    <= pair_dual_sig[p];
                    four_r    <= pair_four_pair[p];
                    man_r     <= (mode == `FPD_MODE_MANUAL);
                    cls_r     <= cls;
                    pct_set_r <= pair_four_pair[p] && !pair_dual_sig[p] && auto_m;
                    // dual loads force the 4.5mA level outside manual mode
                    thr_set_r <= pair_four_pair[p];
                    thr_val_r <= pair_dual_sig[p] | (cls >= 4'h5);
                end else begin
                    en_r      <= en_nxt;
                    disf_r    <= disf_nxt;
                    partial_r <= partial_nxt;
                    pct_set_r <= 1'b0;
                    thr_set_r <= 1'b0;
                end
            end

            // summed four-pair power check qualification
            always @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cut_r <= 1'b0;
                end else begin
                    // suspended in partial or low current
                    cut_r <= pct && four_r && (en_r == 2'b11) && !partial_r &&
                             !below(cur_a, `FPD_I_30MA) &&
                             !below(cur_b, `FPD_I_30MA);
                end
            end

            assign ch_enable[2*p+1 : 2*p]             = en_r;
            assign disconnect_fault_flag[2*p+1 : 2*p] = disf_r;
            assign summed_cut_active[p]               = cut_r;
            assign partial_disconnect[p]              = partial_r;
            assign manual_w[p]                        = man_r;
            assign set_pct[p]                         = pct_set_r;
            assign set_thr[p]                         = thr_set_r;
            assign thr_val[p]                         = thr_val_r;
        end
    endgenerate

endmodule
`default_nettype wire

/* File: fpd_chk_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defines.vh"
module fpd_chk_props #(
    parameter [15:0] DROP_CYC  = 16'h0014,
    parameter [15:0] PULSE_CYC = 16'h0005
) (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        cmd_stb,
    input wire logic [7:0]  cmd_byte,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [7:0]  rd_byte,
    input wire logic        rd_valid,
    input wire logic        supply_stb,
    input wire logic [13:0] supply_code,
    input wire logic [1:0]  pair_turn_on,
    input wire logic [55:0] ch_current,
    input wire logic [3:0]  current_limit_fault,
    input wire logic [3:0]  ch_enable,
    input wire logic [3:0]  disconnect_fault_flag,
    input wire logic [1:0]  summed_cut_active,
    input wire logic [1:0]  partial_disconnect,
    input wire logic [7:0]  four_pair_fault_config
);
    logic [7:0]  cmd_r;   // command last latched
    logic        ptr_r;   // voltage byte pointer, high after the low byte
    logic [13:0] sup_r;   // voltage word as last loaded
    // shadow of the port's byte pointer
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= 8'h00;
            ptr_r <= 1'b0;
            sup_r <= 14'h0000;
        end else begin
            if (cmd_stb) begin
                cmd_r <= cmd_byte;
                ptr_r <= 1'b0;
            end else if (rd_stb && cmd_r == `FPD_CMD_SUPPLY_V) begin
                ptr_r <= ~ptr_r;
            end
            if (supply_stb) begin
                sup_r <= supply_code;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_v_read;
        rd_stb && !cmd_stb && cmd_r == `FPD_CMD_SUPPLY_V;
    endsequence
    sequence s_flag_drop;
        $fell(ch_enable[0]) ##1 !disconnect_fault_flag[0];
    endsequence
    AST_RD_ANSWER: assert property (rd_stb |=> rd_valid ##1 !rd_valid || rd_stb)
        else $error("read answer not one cycle after strobe");
    AST_LOW_BYTE: assert property (s_v_read and !ptr_r |=> rd_byte == $past(sup_r[7:0]))
        else $error("voltage low byte wrong");
    AST_HIGH_ZERO: assert property (s_v_read and ptr_r |=> rd_byte[7:6] == 2'b00)
        else $error("voltage high byte top bits set");
    AST_LIMIT_DROP: assert property (current_limit_fault[0] |=> !ch_enable[0])
        else $error("limit fault left channel on");
    AST_SUMMED_CFG: assert property (summed_cut_active[0] |->
        $past(four_pair_fault_config[2]) && !$past(partial_disconnect[0]))
        else $error("summed check armed while disabled or partial");
    AST_SUMMED_IDLE: assert property (summed_cut_active[0] |->
        $past(ch_current[13:0]) >= `FPD_I_30MA && $past(ch_current[27:14]) >= `FPD_I_30MA)
        else $error("summed check armed below 30mA");
    AST_FLAG_PULSE: assert property (disconnect_fault_flag[0] |-> s_flag_drop)
        else $error("disconnect flag not a drop pulse");
    AST_TURN_ON: assert property (pair_turn_on[0] && current_limit_fault[1:0] == 2'b00
        |=> ch_enable[1:0] == 2'b11)
        else $error("turn on did not power both channels");
    AST_CFG_CAUSE: assert property ($changed(four_pair_fault_config) |->
        $past(wr_stb) || $past(pair_turn_on, 2) != 2'b00 || $past(pair_turn_on, 3) != 2'b00)
        else $error("config changed without write or turn on");
    AST_REENABLE: assert property ($rose(ch_enable[1]) |->
        $past(pair_turn_on[0]) || $past(partial_disconnect[0]))
        else $error("channel came back without cause");
endmodule
`default_nettype wire

/* File: fpd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpd_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] rd_byte,
    input  wire logic       rd_valid,
    output var  logic       cmd_stb,
    output var  logic [7:0] cmd_byte,
    output var  logic       wr_stb,
    output var  logic [7:0] wr_byte,
    output var  logic       rd_stb
);
    // idle values at time zero
    initial begin
        cmd_stb  = 1'b0;
        cmd_byte = 8'h00;
        wr_stb   = 1'b0;
        wr_byte  = 8'h00;
        rd_stb   = 1'b0;
    end
    // select a command; the code is scrambled once released
    task send_cmd(input logic [7:0] code);
        @(posedge sys_clk);
        cmd_stb  <= 1'b1;
        cmd_byte <= code;
        @(posedge sys_clk);
        cmd_stb  <= 1'b0;
        cmd_byte <= ~code;
    endtask
    // one data byte to the selected command
    task write_byte(input logic [7:0] d);
        @(posedge sys_clk);
        wr_stb  <= 1'b1;
        wr_byte <= d;
        @(posedge sys_clk);
        wr_stb  <= 1'b0;
        wr_byte <= ~d;
    endtask
    // one read; a missing valid returns unknown so compares fail
    task read_byte(output logic [7:0] d);
        @(posedge sys_clk);
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        d = (rd_valid === 1'b1) ? rd_byte : 8'hXX;
    endtask
    // two-byte word, low byte first then high
    task read_word(input logic [7:0] code, output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        send_cmd(code);
        read_byte(lo);
        read_byte(hi);
        w = {hi, lo};
    endtask
    // host scaling, 3.662 mV a step, any mode
    function real to_mv(input logic [13:0] c);
        return c * 3.662;
    endfunction
endmodule
`default_nettype wire

/* File: fpd_fault_mgmt_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defines.vh"
module fpd_fault_mgmt_tb_top;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_stb, wr_stb, rd_stb, rd_valid;
    logic [7:0]  cmd_byte, wr_byte, rd_byte, cfg;
    logic        supply_stb = 1'b0;
    logic [13:0] supply_code = 14'h0000;
    logic [1:0]  pair_turn_on = 2'h0, pair_four_pair = 2'h0, pair_dual_sig = 2'h0;
    logic [7:0]  pair_class = 8'h00;
    logic [3:0]  pair_mode = 4'h0, current_limit_fault = 4'h0;
    logic [55:0] ch_current = 56'h0;
    logic [3:0]  ch_enable, disconnect_fault_flag;
    logic [1:0]  summed_cut_active, partial_disconnect;
    int          fails = 0;
    int          tests_run = 0;
    logic [15:0] w;
    // short timers, limit 25 cycles, 20 in manual mode
    fpd_fault_mgmt #(.DROP_CYC(16'h0014), .PULSE_CYC(16'h0005)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_stb(cmd_stb), .cmd_byte(cmd_byte),
        .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_byte(rd_byte),
        .rd_valid(rd_valid), .supply_stb(supply_stb), .supply_code(supply_code),
        .pair_turn_on(pair_turn_on), .pair_four_pair(pair_four_pair),
        .pair_dual_sig(pair_dual_sig), .pair_class(pair_class), .pair_mode(pair_mode),
        .ch_current(ch_current), .current_limit_fault(current_limit_fault),
        .ch_enable(ch_enable), .disconnect_fault_flag(disconnect_fault_flag),
        .summed_cut_active(summed_cut_active), .partial_disconnect(partial_disconnect),
        .four_pair_fault_config(cfg));
    fpd_host_model HOST (.sys_clk(sys_clk), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .cmd_stb(cmd_stb), .cmd_byte(cmd_byte), .wr_stb(wr_stb), .wr_byte(wr_byte),
        .rd_stb(rd_stb));
    always #20 sys_clk = ~sys_clk;
    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task set_i(input logic [13:0] a, input logic [13:0] b);
        @(posedge sys_clk);
        ch_current <= {28'h0000000, b, a};
    endtask
    task wr_cfg(input logic [7:0] d);
        HOST.send_cmd(`FPD_CMD_FAULT_CFG);
        HOST.write_byte(d);
    endtask
    // power pair 0 as a four-pair port
    task power_up(input logic [1:0] mode, input logic dual, input logic [3:0] cls);
        @(posedge sys_clk);
        pair_mode[1:0] <= mode;
        pair_four_pair[0] <= 1'b1;
        pair_dual_sig[0] <= dual;
        pair_class[3:0] <= cls;
        pair_turn_on[0] <= 1'b1;
        @(posedge sys_clk);
        pair_turn_on[0] <= 1'b0;
        cyc(3);
    endtask
    task t_regs;
        HOST.read_word(`FPD_CMD_FAULT_CFG, w);
        chk(w, 16'h0000, "config reset");
        HOST.read_word(`FPD_CMD_SUPPLY_V, w);
        chk(w, 16'h0000, "voltage reset");
        @(posedge sys_clk);
        supply_stb <= 1'b1;
        supply_code <= 14'h3FFF;
        @(posedge sys_clk);
        supply_stb <= 1'b0;
        HOST.read_word(`FPD_CMD_SUPPLY_V, w);
        chk(w, 16'h3FFF, "voltage order");
        wr_cfg(8'hA5);
        HOST.read_word(`FPD_CMD_FAULT_CFG, w);
        chk(w, 16'hA5A5, "config write");
        HOST.send_cmd(`FPD_CMD_SUPPLY_V);
        HOST.write_byte(8'h00);
        HOST.read_word(`FPD_CMD_SUPPLY_V, w);
        chk(w, 16'h3FFF, "voltage is read only");
    endtask
    task auto_case(input logic [1:0] m, input logic d, input logic [3:0] c, input logic [7:0] e);
        wr_cfg(8'h00);
        power_up(m, d, c);
        chk({8'h00, cfg & 8'h05}, {8'h00, e}, "hardware config set");
    endtask
    task t_auto;
        auto_case(`FPD_MODE_SEMI, 1'b0, 4'h3, 8'h04);
        auto_case(`FPD_MODE_AUTO, 1'b1, 4'h4, 8'h01);
        auto_case(`FPD_MODE_AUTO, 1'b0, 4'h6, 8'h05);
    endtask
    task t_summed;
        set_i(14'h01F4, 14'h01F4);
        cyc(4);
        chk({15'h0000, summed_cut_active[0]}, 16'h0001, "summed armed");
        set_i(14'h01F4, 14'h0190);
        cyc(4);
        chk({15'h0000, summed_cut_active[0]}, 16'h0000, "summed below 30mA");
        wr_cfg(8'h01);
        set_i(14'h01F4, 14'h01F4);
        cyc(4);
        chk({15'h0000, summed_cut_active[0]}, 16'h0000, "summed disabled");
        @(posedge sys_clk);
        current_limit_fault[0] <= 1'b1;
        cyc(2);
        chk({14'h0000, ch_enable[1:0]}, 16'h0002, "limit drop");
        @(posedge sys_clk);
        current_limit_fault[0] <= 1'b0;
    endtask
    task t_partial;
        wr_cfg(8'h00);
        power_up(`FPD_MODE_SEMI, 1'b0, 4'h3);
        set_i(14'h01F4, 14'h0050);
        cyc(4);
        chk({14'h0000, ch_enable[1:0]}, 16'h0001, "partial drop");
        chk({14'h0000, summed_cut_active[0], partial_disconnect[0]}, 16'h0001, "partial");
        cyc(40);
        chk({14'h0000, ch_enable[1:0]}, 16'h0001, "remaining kept");
        set_i(14'h044C, 14'h044C);
        cyc(4);
        chk({14'h0000, ch_enable[1:0]}, 16'h0003, "re-enabled above 75mA");
    endtask
    task t_both;
        wr_cfg(8'h00);
        power_up(`FPD_MODE_AUTO, 1'b0, 4'h6);
        set_i(14'h01F4, 14'h0050);
        cyc(40);
        chk({14'h0000, ch_enable[1:0]}, 16'h0003, "above 4.5mA kept");
        set_i(14'h01F4, 14'h0030);
        cyc(40);
        chk({14'h0000, ch_enable[1:0]}, 16'h0003, "one low kept");
        set_i(14'h0030, 14'h0030);
        cyc(10);
        chk({14'h0000, ch_enable[1:0]}, 16'h0003, "both low early");
        cyc(30);
        chk({14'h0000, ch_enable[1:0]}, 16'h0000, "both low off");
        power_up(`FPD_MODE_AUTO, 1'b0, 4'h6);
        wr_cfg(8'h04);
        set_i(14'h01F4, 14'h0050);
        cyc(40);
        chk({14'h0000, ch_enable[1:0]}, 16'h0001, "cleared select 6.5mA");
    endtask
    task t_manual;
        wr_cfg(8'h00);
        set_i(14'h01F4, 14'h01F4);
        power_up(`FPD_MODE_MANUAL, 1'b0, 4'h3);
        set_i(14'h0050, 14'h01F4);
        cyc(10);
        chk({14'h0000, ch_enable[1:0]}, 16'h0003, "manual early");
        cyc(12);
        chk({12'h000, disconnect_fault_flag[1:0], ch_enable[1:0]}, 16'h0006, "manual off");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog, far past a clean run
    initial begin
        #400000;
        fails++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_auto;
        t_summed;
        t_partial;
        t_both;
        t_manual;
        stop_test;
    end
endmodule
bind fpd_fault_mgmt fpd_chk_props #(.DROP_CYC(DROP_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_stb(cmd_stb), .cmd_byte(cmd_byte),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_byte(rd_byte), .rd_valid(rd_valid),
    .supply_stb(supply_stb), .supply_code(supply_code), .pair_turn_on(pair_turn_on),
    .ch_current(ch_current), .current_limit_fault(current_limit_fault),
    .ch_enable(ch_enable), .disconnect_fault_flag(disconnect_fault_flag),
    .summed_cut_active(summed_cut_active), .partial_disconnect(partial_disconnect),
    .four_pair_fault_config(four_pair_fault_config));
`default_nettype wire
